// [bslu_core.sv]
// Bit-string logic unit: word-serial AND, OR, XOR and invert per scan
`timescale 1ns/1ps
module bslu_core
  import bslu_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              scan_start_i,
  input  wire logic              enable_i,
  input  bslu_mode_e             mode_i,
  input  wire logic [LEN_W-1:0]  len_i,
  input  wire logic              in_place_i,
  output logic                   operand_ready_o,
  input  wire logic              word_valid_i,
  input  wire logic [WORD_W-1:0] first_operand_i,
  input  wire logic [WORD_W-1:0] second_operand_i,
  output logic      [WORD_W-1:0] result_o,
  output logic      [ADDR_W-1:0] result_index_o,
  output logic                   result_valid_o,
  output logic                   busy_o,
  output logic                   scan_done_o,
  output logic                   ok_o,
  output logic                   power_out_o
);
  bslu_state_e       state_reg;
  bslu_mode_e        mode_reg;
  logic              in_place_reg;
  logic [ADDR_W-1:0] idx_reg;
  logic [ADDR_W-1:0] last_idx_reg;
  logic [WORD_W-1:0] result_reg;
  logic [ADDR_W-1:0] result_index_reg;
  logic              result_valid_reg;
  logic              done_reg;
  logic              ok_reg;

  logic              start_ok;
  logic              mem_rd_en;
  logic              mem_wr_en;
  logic [WORD_W-1:0] mem_rd_data;
  logic [WORD_W-1:0] operand_b;
  logic [WORD_W-1:0] result_next;
  logic [LEN_W-1:0]  len_eff;
  logic [ADDR_W-1:0] last_idx_next;

  function automatic logic [WORD_W-1:0] bslu_apply(input bslu_mode_e m,
                                                   input logic [WORD_W-1:0] a,
                                                   input logic [WORD_W-1:0] b);
    logic [WORD_W-1:0] r;
    r = WORD_ZERO;
    unique case (m)
      BSLU_MODE_AND: r = a & b;
      BSLU_MODE_OR:  r = a | b;
      BSLU_MODE_XOR: r = a ^ b;
      BSLU_MODE_NOT: r = ~a;
    endcase
    return r;
  endfunction

  assign start_ok        = scan_start_i && (state_reg == ST_IDLE);
  assign busy_o          = (state_reg != ST_IDLE);
  assign operand_ready_o = (state_reg == ST_OPER);
  assign mem_rd_en       = (state_reg == ST_READ);
  assign mem_wr_en       = (state_reg == ST_OPER) && word_valid_i;

  // Length 0 counts as one word, anything above the maximum is clamped
  always_comb
  begin
    len_eff = len_i;
    if (len_i < LEN_MIN)
    begin
      len_eff = LEN_MIN;
    end
    else if (len_i > LEN_MAX)
    begin
      len_eff = LEN_MAX;
    end
    last_idx_next = ADDR_W'(len_eff - LEN_MIN);
  end

  // In place, the second operand is the stored destination word
  assign operand_b   = in_place_reg ? mem_rd_data : second_operand_i;
  assign result_next = bslu_apply(mode_reg, first_operand_i, operand_b);

  bslu_word_mem #(
    .W     (WORD_W),
    .DEPTH (MAX_LEN),
    .AW    (ADDR_W)
  ) u_dest_mem (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mem_wr_en),
    .wr_addr_i (idx_reg),
    .wr_data_i (result_next),
    .rd_en_i   (mem_rd_en),
    .rd_addr_i (idx_reg),
    .rd_data_o (mem_rd_data)
  );

  // Scan sequencing, word by word from the least significant word
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      idx_reg   <= IDX_FIRST;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          idx_reg <= IDX_FIRST;
          if (start_ok && enable_i)
          begin
            state_reg <= ST_READ;
          end
        end
        ST_READ:
        begin
          state_reg <= ST_OPER;
        end
        ST_OPER:
        begin
          if (word_valid_i)
          begin
            if (idx_reg == last_idx_reg)
            begin
              state_reg <= ST_DONE;
            end
            else
            begin
              idx_reg   <= idx_reg + IDX_STEP;
              state_reg <= ST_READ;
            end
          end
        end
        ST_DONE:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Scan settings captured at the start of an enabled scan
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      mode_reg     <= BSLU_MODE_AND;
      in_place_reg <= 1'b0;
      last_idx_reg <= IDX_FIRST;
    end
    else if (start_ok && enable_i)
    begin
      mode_reg     <= mode_i;
      in_place_reg <= in_place_i;
      last_idx_reg <= last_idx_next;
    end
  end

  // Result word stream
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      result_reg       <= WORD_ZERO;
      result_index_reg <= IDX_FIRST;
      result_valid_reg <= 1'b0;
    end
    else
    begin
      result_valid_reg <= mem_wr_en;
      if (mem_wr_en)
      begin
        result_reg       <= result_next;
        result_index_reg <= idx_reg;
      end
    end
  end

  // Ok and done; ok holds until the next scan starts
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      done_reg <= 1'b0;
      ok_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start_ok && !enable_i)
      begin
        done_reg <= 1'b1;
        ok_reg   <= 1'b0;
      end
      else if (start_ok)
      begin
        ok_reg <= 1'b0;
      end
      else if (state_reg == ST_DONE)
      begin
        done_reg <= 1'b1;
        ok_reg   <= 1'b1;
      end
    end
  end

  assign result_o       = result_reg;
  assign result_index_o = result_index_reg;
  assign result_valid_o = result_valid_reg;
  assign scan_done_o    = done_reg;
  assign ok_o           = ok_reg;
  assign power_out_o    = ok_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  and_result_a: assert property (
    (mem_wr_en && mode_reg == BSLU_MODE_AND)
    |=> result_valid_o && result_o == ($past(first_operand_i) & $past(operand_b)))
    else $error("AND result word wrong");

  or_result_a: assert property (
    (mem_wr_en && mode_reg == BSLU_MODE_OR)
    |=> result_o == ($past(first_operand_i) | $past(operand_b)))
    else $error("OR result word wrong");

  xor_result_a: assert property (
    (mem_wr_en && mode_reg == BSLU_MODE_XOR && !in_place_reg)
    |=> result_o == ($past(first_operand_i) ^ $past(second_operand_i)))
    else $error("XOR result word wrong");

  invert_result_a: assert property (
    (mem_wr_en && mode_reg == BSLU_MODE_NOT) |=> result_o == ~$past(first_operand_i))
    else $error("Invert result word wrong");

  xor_toggle_a: assert property (
    (mem_wr_en && mode_reg == BSLU_MODE_XOR && in_place_reg)
    |=> result_o == ($past(first_operand_i) ^ $past(mem_rd_data)))
    else $error("In-place XOR did not toggle");

  disabled_scan_a: assert property (
    (start_ok && !enable_i) |=> scan_done_o && !ok_o && !busy_o && !result_valid_o)
    else $error("Disabled scan misbehaved");

  idle_no_write_a: assert property (
    !busy_o |-> !mem_wr_en ##1 !result_valid_o)
    else $error("Write outside an enabled scan");

  // A second done right away can only be a disabled scan started while done stood
  enabled_ok_a: assert property (
    (state_reg == ST_DONE) |=> scan_done_o && ok_o && power_out_o ##1 (!scan_done_o || !ok_o))
    else $error("Enabled scan ended without ok");

  word_order_a: assert property (
    (mem_wr_en && idx_reg != last_idx_reg) |=> state_reg == ST_READ && idx_reg == $past(idx_reg) + IDX_STEP)
    else $error("Word order broken");

  last_word_a: assert property (
    (mem_wr_en && idx_reg == last_idx_reg) |=> state_reg == ST_DONE ##1 scan_done_o)
    else $error("Scan length not honoured");

  first_word_a: assert property (
    (start_ok && enable_i) |=> (state_reg == ST_READ) && (idx_reg == IDX_FIRST))
    else $error("Scan did not begin at the first word");

  scan_open_a: assert property (
    (start_ok && enable_i) |=> busy_o && !ok_o && !power_out_o)
    else $error("Enabled scan did not open");

  len_clamp_a: assert property (
    (start_ok && enable_i && (len_i > LEN_MAX)) |=> (last_idx_reg == ADDR_W'(MAX_LEN - 1)))
    else $error("Length above maximum not clamped");

  len_floor_a: assert property (
    (start_ok && enable_i && (len_i < LEN_MIN)) |=> (last_idx_reg == IDX_FIRST))
    else $error("Zero length not taken as one word");

  result_range_a: assert property (
    result_valid_o |-> (result_index_o <= last_idx_reg))
    else $error("Result word beyond string end");

  ready_gap_a: assert property (
    (operand_ready_o && word_valid_i) |=> !operand_ready_o)
    else $error("Next word taken without a read cycle");

  done_idle_a: assert property (
    scan_done_o |-> !busy_o)
    else $error("Scan done while still busy");

  ok_stable_a: assert property (
    (!start_ok && (state_reg != ST_DONE)) |=> $stable(ok_o) && (power_out_o == ok_o))
    else $error("Ok changed outside a scan boundary");

  xor_power_a: assert property (
    (state_reg == ST_DONE && mode_reg == BSLU_MODE_XOR) |=> power_out_o)
    else $error("XOR scan did not pass power flow");

  disabled_keep_a: assert property (
    (start_ok && !enable_i) |=> $stable(mode_reg) && $stable(in_place_reg) && $stable(last_idx_reg))
    else $error("Disabled scan changed scan settings");

  disabled_scan_c: cover property (start_ok && !enable_i);
  multi_word_c:    cover property (mem_wr_en && idx_reg != IDX_FIRST && idx_reg == last_idx_reg);
  in_place_xor_c:  cover property (mem_wr_en && in_place_reg && mode_reg == BSLU_MODE_XOR);
  full_length_c:   cover property (mem_wr_en && idx_reg == ADDR_W'(MAX_LEN - 1));
  xor_power_c:     cover property (state_reg == ST_DONE && mode_reg == BSLU_MODE_XOR);
endmodule

// [bslu_pkg.sv]
// Constants and types shared by the bit-string logic unit
// Function
// - AND, OR, XOR and invert each act on one operand word at a time.
// - Operand strings may be selected up to 256 words long.
// - Multi-word operand is one bit string, bit 1 of word one is LSB.
// - Each enabled scan walks operand pairs from the least significant end upward.
// - AND writes 1 only where both operand bits are 1.
// - OR writes 1 where either operand bit is 1.
// - XOR writes 1 exactly where the two operand bits differ.
// - Operation and result update happen only while enable is asserted; the code samples enable only at scan start and ignores it after that.
// - Ok is asserted for every enabled scan of AND, OR and XOR.
// - XOR passes power flow onward whenever enable is received.
// - In-place XOR toggles each destination bit whose first-operand bit is 1.
// - Overlapping first and second operands still give the correct bitwise result.
// - Each operand word holds 16 independent bits.
package bslu_pkg;
  localparam int WORD_W  = 16;
  localparam int MAX_LEN = 256;
  localparam int LEN_W   = 9;
  localparam int ADDR_W  = 8;

  localparam logic [LEN_W-1:0]  LEN_MIN    = 9'h001;
  localparam logic [LEN_W-1:0]  LEN_MAX    = 9'h100;
  localparam logic [ADDR_W-1:0] IDX_FIRST  = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_STEP   = 8'h01;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;

  typedef enum logic [1:0] {
    BSLU_MODE_AND,
    BSLU_MODE_OR,
    BSLU_MODE_XOR,
    BSLU_MODE_NOT
  } bslu_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_OPER,
    ST_DONE
  } bslu_state_e;
endpackage

// [bslu_seq_model.sv]
// Scan sequencer model that offers operand word pairs to the logic unit
`timescale 1ns/1ps
module bslu_seq_model
  import bslu_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              start_i,
  input  wire logic              ready_i,
  input  wire logic              slow_i,
  output logic                   valid_o,
  output logic      [WORD_W-1:0] first_o,
  output logic      [WORD_W-1:0] second_o
);
  logic [WORD_W-1:0] a_mem [MAX_LEN];
  logic [WORD_W-1:0] b_mem [MAX_LEN];
  int                idx = 0;
  int                wait_n = 0;

  initial
  begin
    valid_o = 1'b0;
    first_o = 16'h0000;
    second_o = 16'h0000;
  end

  always @(posedge clk_sys_i)
  begin
    if (start_i)
      idx = 0;
    else if (valid_o && ready_i)
      idx = idx + 1;
    wait_n = (ready_i && !valid_o) ? wait_n + 1 : 0;
    #1;
    // Slow mode lets the unit wait three cycles; an idle bus inverts its previous value every cycle
    valid_o = ready_i && (!slow_i || wait_n >= 3) && idx < MAX_LEN;
    first_o = valid_o ? a_mem[idx] : ~first_o;
    second_o = valid_o ? b_mem[idx] : ~second_o;
  end
endmodule

// [bslu_word_mem.sv]
// Destination word store with registered read data
`timescale 1ns/1ps
module bslu_word_mem
  import bslu_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = MAX_LEN,
  parameter int AW    = ADDR_W
)
(
  input  wire logic          clk_sys_i,
  input  wire logic          sys_rst_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o
);
  logic [W-1:0] mem_reg [DEPTH];

  // Cleared at reset so an in-place toggle starts from a known word
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_reg[i] <= '0;
      end
    end
    else if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= '0;
    end
    else if (rd_en_i)
    begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end
endmodule

// [tb.sv]
// Self-checking testbench for the bit-string logic unit
`timescale 1ns/1ps
module tb;
  import bslu_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              scan_start_i = 1'b0;
  logic              enable_i = 1'b0;
  bslu_mode_e        mode_i = BSLU_MODE_AND;
  logic [LEN_W-1:0]  len_i = LEN_MIN;
  logic              in_place_i = 1'b0;
  logic              slow = 1'b0;
  logic              operand_ready_o, word_valid_i, result_valid_o, busy_o, scan_done_o, ok_o, power_out_o;
  logic [WORD_W-1:0] first_operand_i, second_operand_i, result_o;
  logic [ADDR_W-1:0] result_index_o;
  logic [WORD_W-1:0] res [MAX_LEN];
  logic [WORD_W-1:0] dst [MAX_LEN];
  int                nres = 0;
  int                n_fail = 0;
  int                checked = 0;
  int                cycles = 0;

  bslu_core bslu_core_inst (
    .clk_sys_i        (clk_sys_i),
    .sys_rst_i        (sys_rst_i),
    .scan_start_i     (scan_start_i),
    .enable_i         (enable_i),
    .mode_i           (mode_i),
    .len_i            (len_i),
    .in_place_i       (in_place_i),
    .operand_ready_o  (operand_ready_o),
    .word_valid_i     (word_valid_i),
    .first_operand_i  (first_operand_i),
    .second_operand_i (second_operand_i),
    .result_o         (result_o),
    .result_index_o   (result_index_o),
    .result_valid_o   (result_valid_o),
    .busy_o           (busy_o),
    .scan_done_o      (scan_done_o),
    .ok_o             (ok_o),
    .power_out_o      (power_out_o)
  );
  bslu_seq_model bslu_seq_model_inst (.clk_sys_i(clk_sys_i), .start_i(scan_start_i), .ready_i(operand_ready_o),
    .slow_i(slow), .valid_o(word_valid_i), .first_o(first_operand_i), .second_o(second_operand_i));

  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
  begin
    if (result_valid_o === 1'b1)
    begin
      res[result_index_o] = result_o;
      nres++;
    end
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic fill(input int k);
    for (int i = 0; i < MAX_LEN; i++)
    begin
      bslu_seq_model_inst.a_mem[i] = WORD_W'(i * 40503 + k);
      bslu_seq_model_inst.b_mem[i] = WORD_W'(i * 7919 ^ (k << 3));
    end
  endtask

  task automatic run_scan(input bslu_mode_e m, input logic en, input int len, input logic ip);
    int n;
    int cyc;
    logic [WORD_W-1:0] e;
    n = (len == 0) ? 1 : ((len > MAX_LEN) ? MAX_LEN : len);
    nres = 0;
    foreach (res[i]) res[i] = 'x;
    mode_i = m;
    enable_i = en;
    len_i = LEN_W'(len);
    in_place_i = ip;
    scan_start_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    scan_start_i = 1'b0;
    cyc = 0;
    while (scan_done_o !== 1'b1 && cyc < 2000)
    begin
      @(posedge clk_sys_i);
      #1;
      cyc++;
    end
    check(scan_done_o, 1'b1, "scan done");
    check(ok_o, en, "ok");
    check(power_out_o, en, "power out");
    check(busy_o, 1'b0, "busy");
    check(WORD_W'(nres), en ? WORD_W'(n) : 16'h0000, "word count");
    for (int i = 0; i < n && en; i++)
    begin
      e = ip ? dst[i] : bslu_seq_model_inst.b_mem[i];
      case (m)
        BSLU_MODE_AND: e = bslu_seq_model_inst.a_mem[i] & e;
        BSLU_MODE_OR: e = bslu_seq_model_inst.a_mem[i] | e;
        BSLU_MODE_XOR: e = bslu_seq_model_inst.a_mem[i] ^ e;
        default: e = ~bslu_seq_model_inst.a_mem[i];
      endcase
      check(res[i], e, "result word");
      dst[i] = e;
    end
  endtask

  task automatic t_modes;
    fill(1);
    for (int m = 0; m < 4; m++)
      run_scan(bslu_mode_e'(m), 1'b1, 3, 1'b0);
    $display("modes done");
  endtask

  task automatic t_overlap;
    for (int i = 0; i < 2; i++)
      bslu_seq_model_inst.b_mem[i] = bslu_seq_model_inst.a_mem[i];
    run_scan(BSLU_MODE_AND, 1'b1, 2, 1'b0);
    run_scan(BSLU_MODE_OR, 1'b1, 2, 1'b0);
    $display("overlap done");
  endtask

  task automatic t_disabled;
    run_scan(BSLU_MODE_XOR, 1'b0, 4, 1'b0);
    for (int i = 0; i < 4; i++)
      bslu_seq_model_inst.a_mem[i] = 16'h0000;
    run_scan(BSLU_MODE_OR, 1'b1, 4, 1'b1);
    $display("disabled done");
  endtask

  task automatic t_toggle;
    fill(7);
    slow = 1'b1;
    for (int k = 0; k < 3; k++)
      run_scan(BSLU_MODE_XOR, 1'b1, 2, 1'b1);
    slow = 1'b0;
    $display("toggle done");
  endtask

  task automatic t_length;
    run_scan(BSLU_MODE_AND, 1'b1, 0, 1'b0);
    run_scan(BSLU_MODE_OR, 1'b1, 300, 1'b0);
    $display("length done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    foreach (dst[i]) dst[i] = 16'h0000;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check(ok_o, 1'b0, "ok in reset");
    check(result_valid_o, 1'b0, "valid in reset");
    sys_rst_i = 1'b0;
    t_modes();
    t_overlap();
    t_disabled();
    t_toggle();
    t_length();
    end_of_test();
  end
endmodule
